// ==== brpcs_pkg.sv ====
// Shared constants and types for the base-R PCS status register bank.
// Assumes a single management clock domain with an active-low async reset.
package brpcs_pkg;

  // Management frame addressing
  localparam logic [4:0]  DEVAD_PCS          = 5'h03;
  localparam logic [4:0]  DEVAD_VEND         = 5'h1E;

  // Register offsets within each device address
  localparam logic [15:0] LINK_FAULT_OFS     = 16'h0001;
  localparam logic [15:0] PRESENCE_FAULT_OFS = 16'h0008;
  localparam logic [15:0] LOCK_BER_OFS       = 16'h0020;
  localparam logic [15:0] LAT_CNT_OFS        = 16'h0021;
  localparam logic [15:0] SEED_A0_OFS        = 16'h0022;
  localparam logic [15:0] SEED_A1_OFS        = 16'h0023;
  localparam logic [15:0] VEND_ERRBLK_OFS    = 16'h0010;

  // Field positions
  localparam int unsigned FAULT_SUM_BIT      = 7;
  localparam int unsigned RX_LINK_LAT_BIT    = 2;
  localparam int unsigned LP_ABIL_BIT        = 1;
  localparam int unsigned PRESENCE_LSB       = 14;
  localparam int unsigned TX_FAULT_BIT       = 11;
  localparam int unsigned RX_FAULT_BIT       = 10;
  localparam int unsigned BASE_R_CAP_BIT     = 0;
  localparam int unsigned LINK_LIVE_BIT      = 12;
  localparam int unsigned PRBS31_BIT         = 2;
  localparam int unsigned HIBER_LIVE_BIT     = 1;
  localparam int unsigned LOCK_LIVE_BIT      = 0;
  localparam int unsigned LOCK_LAT_BIT       = 15;
  localparam int unsigned HIBER_LAT_BIT      = 14;
  localparam int unsigned BER_CNT_LSB        = 8;
  localparam int unsigned ERR_CNT_LSB        = 0;

  // Fixed field values and reset values
  localparam logic [1:0]  PRESENCE_CODE      = 2'h2;
  localparam logic [15:0] SEED_RESET         = 16'h0000;

  // Frame bit counts
  localparam logic [5:0]  PREAMBLE_BITS      = 6'h20;
  localparam logic [5:0]  HDR_LAST           = 6'h0D;
  localparam logic [5:0]  DATA_BITS          = 6'h10;
  localparam logic [5:0]  SKIP_LAST          = 6'h11;

  // Frame opcodes
  localparam logic [1:0]  OP_ADDR            = 2'h0;
  localparam logic [1:0]  OP_WRITE           = 2'h1;
  localparam logic [1:0]  OP_RDINC           = 2'h2;
  localparam logic [1:0]  OP_READ            = 2'h3;

  localparam int unsigned SYNC_W             = 2;

  typedef enum logic [2:0] {
    S_PRE   = 3'h0,
    S_HDR   = 3'h1,
    S_TA    = 3'h2,
    S_WDATA = 3'h3,
    S_RDATA = 3'h4,
    S_SKIP  = 3'h5
  } brpcs_state_e;

  // Live conditions and event pulses from the PCS datapath
  typedef struct packed {
    logic tx_fault;
    logic rx_fault;
    logic rx_link_up;
    logic hi_ber;
    logic block_lock;
    logic bad_sh_entry;
    logic rx_e_entry;
  } brpcs_pcs_stat_s;

  typedef struct packed {
    logic [SYNC_W-1:0] s1;
    logic [SYNC_W-1:0] s2;
    logic [SYNC_W-1:0] s3;
    logic [SYNC_W-1:0] q;
  } brpcs_sync_s;

  typedef struct packed {
    brpcs_state_e st;
    logic [5:0]   cnt;
    logic [15:0]  shift;
    logic [1:0]   op;
    logic [4:0]   dev;
    logic [15:0]  addr3;
    logic [15:0]  addr30;
    logic [15:0]  seed0;
    logic [15:0]  seed1;
    logic         tx_lat;
    logic         rx_lat;
    logic         link_lat;
    logic         hiber_lat;
    logic         lock_lat;
    logic [5:0]   ber_cnt;
    logic [7:0]   err_cnt;
    logic         mdc_d;
    logic         mdio_o;
    logic         mdio_oe;
  } brpcs_regs_s;

endpackage

// ==== brpcs_pin_sync.sv ====
// Three-stage pin synchroniser with agreement filter.
// Assumes inputs are asynchronous to core_clk; output is core_clk level.
`timescale 1ns/1ps
module brpcs_pin_sync (
  // Clock and reset
  input  wire logic                       core_clk,
  input  wire logic                       reset_n,
  // Pins and filtered levels
  input  wire logic [brpcs_pkg::SYNC_W-1:0] pin_in,
  output logic      [brpcs_pkg::SYNC_W-1:0] level_out
);
  import brpcs_pkg::*;

  brpcs_sync_s            sy_r;
  brpcs_sync_s            sy_nxt;
  logic [SYNC_W-1:0]      q_nxt;

  // Accept a change only when stages two and three agree
  for (genvar i = 0; i < SYNC_W; i++) begin : g_bit
    assign q_nxt[i] = (sy_r.s2[i] == sy_r.s3[i]) ? sy_r.s3[i] : sy_r.q[i];
  end

  // Next state; first stage feeds only the second
  always_comb begin
    sy_nxt    = sy_r;
    sy_nxt.s1 = pin_in;
    sy_nxt.s2 = sy_r.s1;
    sy_nxt.s3 = sy_r.s2;
    sy_nxt.q  = q_nxt;
  end

  // State register
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sy_r <= '0;
    end else begin
      sy_r <= sy_nxt;
    end
  end

  assign level_out = sy_r.q;

endmodule

// ==== brpcs_status_regs.sv ====
// Management-frame slave holding the base-R PCS status, latch and
// counter registers plus the first two test seed words.
// Assumes MDC/MDIO arrive asynchronously and PCS inputs share core_clk.
`timescale 1ns/1ps
module brpcs_status_regs #(
  parameter logic [4:0] PORT_ADDR = 5'h00
) (
  // Clock and reset
  input  wire logic                       core_clk,
  input  wire logic                       reset_n,
  // Management pins
  input  wire logic                       mdc,
  input  wire logic                       mdio_i,
  output logic                            mdio_o,
  output logic                            mdio_oe,
  // PCS side
  input  wire logic                       kr_mode,
  input  wire brpcs_pkg::brpcs_pcs_stat_s pcs_stat,
  output logic      [31:0]                test_seed_a
);
  import brpcs_pkg::*;

  brpcs_regs_s          r_r;
  brpcs_regs_s          r_nxt;
  logic [SYNC_W-1:0]    pins_q;
  logic                 mdc_q;
  logic                 mdio_q;
  logic                 rise;
  logic                 is_read;
  logic [15:0]          cur_addr;
  logic                 snap;
  logic                 rd_link;
  logic                 rd_pres;
  logic                 rd_lat;
  logic                 rd_vend;
  logic                 fault_summary;
  logic [15:0]          rd_word;
  logic [15:0]          hdr;
  logic                 hdr_match;

  // Both pins pass the same filter so their skew stays equal
  brpcs_pin_sync u_sync (
    .core_clk  (core_clk),
    .reset_n   (reset_n),
    .pin_in    ({mdc, mdio_i}),
    .level_out (pins_q)
  );
  assign mdc_q  = pins_q[1];
  assign mdio_q = pins_q[0];

  // Frame decode helpers
  assign rise     = mdc_q & ~r_r.mdc_d;
  assign is_read  = (r_r.op == OP_READ) || (r_r.op == OP_RDINC);
  assign cur_addr = (r_r.dev == DEVAD_PCS) ? r_r.addr3 : r_r.addr30;
  assign hdr      = {r_r.shift[14:0], mdio_q};
  assign hdr_match = (hdr[13:12] == 2'h0) && (hdr[9:5] == PORT_ADDR) &&
                     ((hdr[4:0] == DEVAD_PCS) || (hdr[4:0] == DEVAD_VEND)) &&
                     kr_mode;

  // Read snapshot moment and which register it hits
  assign snap    = rise && (r_r.st == S_TA) && is_read;
  assign rd_link = snap && (r_r.dev == DEVAD_PCS) &&
                   (cur_addr == LINK_FAULT_OFS);
  assign rd_pres = snap && (r_r.dev == DEVAD_PCS) &&
                   (cur_addr == PRESENCE_FAULT_OFS);
  assign rd_lat  = snap && (r_r.dev == DEVAD_PCS) &&
                   (cur_addr == LAT_CNT_OFS);
  assign rd_vend = snap && (r_r.dev == DEVAD_VEND) &&
                   (cur_addr == VEND_ERRBLK_OFS);

  // summary of live and latched faults
  assign fault_summary = pcs_stat.tx_fault | pcs_stat.rx_fault |
                         r_r.tx_lat | r_r.rx_lat;

  // Read data mux; unmapped offsets read as zero
  always_comb begin
    rd_word = 16'h0000;
    if (r_r.dev == DEVAD_PCS) begin
      case (cur_addr)
        LINK_FAULT_OFS: begin
          rd_word[FAULT_SUM_BIT]   = fault_summary;
          rd_word[RX_LINK_LAT_BIT] = r_r.link_lat;
          rd_word[LP_ABIL_BIT]     = 1'b1;
        end
        PRESENCE_FAULT_OFS: begin
          rd_word[PRESENCE_LSB+:2] = PRESENCE_CODE;
          rd_word[TX_FAULT_BIT]    = r_r.tx_lat;
          rd_word[RX_FAULT_BIT]    = r_r.rx_lat;
          rd_word[BASE_R_CAP_BIT]  = 1'b1;
        end
        LOCK_BER_OFS: begin
          rd_word[LINK_LIVE_BIT]   = pcs_stat.rx_link_up;
          rd_word[PRBS31_BIT]      = 1'b1;
          rd_word[HIBER_LIVE_BIT]  = pcs_stat.hi_ber;
          rd_word[LOCK_LIVE_BIT]   = pcs_stat.block_lock;
        end
        LAT_CNT_OFS: begin
          rd_word[LOCK_LAT_BIT]      = r_r.lock_lat;
          rd_word[HIBER_LAT_BIT]     = r_r.hiber_lat;
          rd_word[BER_CNT_LSB+:6]    = r_r.ber_cnt;
          rd_word[ERR_CNT_LSB+:8]    = r_r.err_cnt;
        end
        SEED_A0_OFS: rd_word = r_r.seed0;
        SEED_A1_OFS: rd_word = r_r.seed1;
        default:     rd_word = 16'h0000;
      endcase
    end else if (cur_addr == VEND_ERRBLK_OFS) begin
      rd_word[ERR_CNT_LSB+:8] = r_r.err_cnt;
    end
  end

  // Next-state logic: latches, counters and frame engine
  always_comb begin
    r_nxt       = r_r;
    r_nxt.mdc_d = mdc_q;

    // transmit latch, set wins over read clear
    r_nxt.tx_lat    = (rd_pres ? 1'b0 : r_r.tx_lat) | pcs_stat.tx_fault;
    // receive latch, re-armed by the 3.8 read
    r_nxt.rx_lat    = (rd_pres ? 1'b0 : r_r.rx_lat) | pcs_stat.rx_fault;
    r_nxt.link_lat  = (rd_link ? 1'b1 : r_r.link_lat) & pcs_stat.rx_link_up;
    r_nxt.hiber_lat = (rd_lat ? 1'b0 : r_r.hiber_lat) | pcs_stat.hi_ber;
    r_nxt.lock_lat  = (rd_lat ? 1'b1 : r_r.lock_lat) & pcs_stat.block_lock;

    // saturating count, an event in the read cycle survives
    if (rd_lat) begin
      r_nxt.ber_cnt = {5'h00, pcs_stat.bad_sh_entry};
    end else if (pcs_stat.bad_sh_entry && (r_r.ber_cnt != 6'h3F)) begin
      r_nxt.ber_cnt = r_r.ber_cnt + 6'h01;
    end
    // either location clears the one counter
    if (rd_lat || rd_vend) begin
      r_nxt.err_cnt = {7'h00, pcs_stat.rx_e_entry};
    end else if (pcs_stat.rx_e_entry && (r_r.err_cnt != 8'hFF)) begin
      r_nxt.err_cnt = r_r.err_cnt + 8'h01;
    end

    // Frame engine steps once per filtered MDC rising edge
    if (rise) begin
      case (r_r.st)
        S_PRE: begin
          if (mdio_q) begin
            if (r_r.cnt != PREAMBLE_BITS) begin
              r_nxt.cnt = r_r.cnt + 6'h01;
            end
          end else if (r_r.cnt == PREAMBLE_BITS) begin
            r_nxt.st    = S_HDR;
            r_nxt.cnt   = 6'h01;
            r_nxt.shift = 16'h0000;
          end else begin
            r_nxt.cnt = 6'h00;
          end
        end
        S_HDR: begin
          r_nxt.shift = hdr;
          r_nxt.cnt   = r_r.cnt + 6'h01;
          if (r_r.cnt == HDR_LAST) begin
            r_nxt.cnt = 6'h00;
            r_nxt.op  = hdr[11:10];
            r_nxt.dev = hdr[4:0];
            r_nxt.st  = hdr_match ? S_TA : S_SKIP;
          end
        end
        S_TA: begin
          if (is_read) begin
            // Drive the turnaround zero, then data
            r_nxt.mdio_oe = 1'b1;
            r_nxt.mdio_o  = 1'b0;
            r_nxt.shift   = rd_word;
            r_nxt.cnt     = 6'h00;
            r_nxt.st      = S_RDATA;
          end else if (r_r.cnt == 6'h01) begin
            r_nxt.cnt = 6'h00;
            r_nxt.st  = S_WDATA;
          end else begin
            r_nxt.cnt = r_r.cnt + 6'h01;
          end
        end
        S_WDATA: begin
          r_nxt.shift = hdr;
          r_nxt.cnt   = r_r.cnt + 6'h01;
          if (r_r.cnt == DATA_BITS - 6'h01) begin
            r_nxt.cnt = 6'h00;
            r_nxt.st  = S_PRE;
            if (r_r.op == OP_ADDR) begin
              if (r_r.dev == DEVAD_PCS) begin
                r_nxt.addr3 = hdr;
              end else begin
                r_nxt.addr30 = hdr;
              end
            end else if ((r_r.op == OP_WRITE) &&
                         (r_r.dev == DEVAD_PCS)) begin
              // seed words; other offsets ignore writes
              if (r_r.addr3 == SEED_A0_OFS) begin
                r_nxt.seed0 = hdr;
              end
              if (r_r.addr3 == SEED_A1_OFS) begin
                r_nxt.seed1 = hdr;
              end
            end
          end
        end
        S_RDATA: begin
          if (r_r.cnt != DATA_BITS) begin
            r_nxt.mdio_o = r_r.shift[15];
            r_nxt.shift  = {r_r.shift[14:0], 1'b0};
            r_nxt.cnt    = r_r.cnt + 6'h01;
          end else begin
            // Release the line after the last bit is sampled
            r_nxt.mdio_oe = 1'b0;
            r_nxt.mdio_o  = 1'b0;
            r_nxt.cnt     = 6'h00;
            r_nxt.st      = S_PRE;
            if (r_r.op == OP_RDINC) begin
              if (r_r.dev == DEVAD_PCS) begin
                r_nxt.addr3 = r_r.addr3 + 16'h0001;
              end else begin
                r_nxt.addr30 = r_r.addr30 + 16'h0001;
              end
            end
          end
        end
        S_SKIP: begin
          r_nxt.cnt = r_r.cnt + 6'h01;
          if (r_r.cnt == SKIP_LAST) begin
            r_nxt.cnt = 6'h00;
            r_nxt.st  = S_PRE;
          end
        end
        default: begin
          r_nxt.st      = S_PRE;
          r_nxt.cnt     = 6'h00;
          r_nxt.mdio_oe = 1'b0;
        end
      endcase
    end
  end

  // State register; all latches and counters start cleared
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      r_r <= '0;
    end else begin
      r_r <= r_nxt;
    end
  end

  // Outputs straight from flops
  assign mdio_o      = r_r.mdio_o;
  assign mdio_oe     = r_r.mdio_oe;
  assign test_seed_a = {r_r.seed1, r_r.seed0};

  // Checks on the documented register behaviour
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  AST_FAULT_SUM: assert property (
    (pcs_stat.tx_fault || pcs_stat.rx_fault) |-> fault_summary)
    else $error("fault summary low during a fault");
  AST_FAULT_HOLD: assert property (
    (r_r.rx_lat && !rd_pres) |=> fault_summary)
    else $error("fault summary dropped before 3.8 read");
  AST_LINK_LL: assert property (
    (!r_r.link_lat && !rd_link) |=> !r_r.link_lat)
    else $error("link latch rose without a read");
  AST_CONST_BITS: assert property (
    rd_pres |=> (r_r.shift[15:14] == PRESENCE_CODE) && r_r.shift[0])
    else $error("presence or capability bits wrong");
  AST_TX_LH: assert property (
    pcs_stat.tx_fault |=> r_r.tx_lat ##1 (r_r.tx_lat || $past(rd_pres)))
    else $error("transmit fault latch lost");
  AST_LOCK_LL: assert property (
    !pcs_stat.block_lock |=> !r_r.lock_lat)
    else $error("block lock latch not low");
  AST_BER_CLR: assert property (
    (rd_lat && !pcs_stat.bad_sh_entry) |=> (r_r.ber_cnt == 6'h00))
    else $error("bad header count not cleared");
  AST_ERR_INC: assert property (
    (pcs_stat.rx_e_entry && !rd_lat && !rd_vend && r_r.err_cnt != 8'hFF)
    |=> (r_r.err_cnt == 8'($past(r_r.err_cnt) + 8'h01)))
    else $error("errored block count did not step");
  AST_VEND_CLR: assert property (
    (rd_vend && !pcs_stat.rx_e_entry) |=> (r_r.err_cnt == 8'h00))
    else $error("vendor read did not clear counter");
  AST_TA_DRIVE: assert property (
    snap |=> (r_r.mdio_oe && !r_r.mdio_o && r_r.st == S_RDATA))
    else $error("turnaround zero not driven");
  AST_REARM: assert property (
    rd_pres |=> (r_r.tx_lat == $past(pcs_stat.tx_fault)))
    else $error("transmit latch not re-armed");
  AST_RX_LH: assert property (
    pcs_stat.rx_fault |=> r_r.rx_lat)
    else $error("receive fault latch not set");
  AST_FAULT_CLR: assert property (
    (rd_pres && !pcs_stat.tx_fault && !pcs_stat.rx_fault)
    |=> (!r_r.tx_lat && !r_r.rx_lat))
    else $error("fault latches not cleared by 3.8 read");
  AST_HIBER_LH: assert property (
    pcs_stat.hi_ber |=> r_r.hiber_lat)
    else $error("error rate latch not set");
  AST_LINK_REARM: assert property (
    (rd_link && pcs_stat.rx_link_up) |=> r_r.link_lat)
    else $error("link latch not re-armed by read");
  AST_SEED_HOLD: assert property (
    (r_r.st != S_WDATA) |=> $stable({r_r.seed1, r_r.seed0}))
    else $error("seed changed outside a write");
  AST_SKIP_QUIET: assert property (
    (r_r.st == S_SKIP) |-> !r_r.mdio_oe)
    else $error("line driven during a refused frame");

  COV_READ: cover property (snap ##1 r_r.mdio_oe);
  COV_SEED_WR: cover property ($changed(r_r.seed0));
  COV_CNT_CLR: cover property (rd_lat && r_r.err_cnt != 8'h00);
  COV_SKIP: cover property (r_r.st == S_SKIP);

endmodule

// ==== brpcs_mdio_host.sv ====
// Management host model that sends Clause 45 frames on MDC/MDIO.
// Assumes the bench resolves the shared data wire with a pull-up.
`timescale 1ns/1ps
module brpcs_mdio_host #(
  parameter int HALF = 6
) (
  // Clock
  input  wire logic core_clk,
  // Management pins
  input  wire logic mdio_wire,
  output logic      mdc,
  output logic      host_o,
  output logic      host_oe
);
  import brpcs_pkg::*;

  logic [4:0] prtad;  // Port address placed in frames

  // Idle: clock parked low, data line released
  initial begin
    mdc     = 1'b0;
    host_o  = 1'b1;
    host_oe = 1'b0;
    prtad   = 5'h05;
  end

  // Data moves after each clock fall, the device drives only on reads.
  // MDC halves stay above five core clocks so the pin filter keeps up.
  // devad chosen by caller
  task automatic frame(input logic [1:0] op, input logic [4:0] dev,
                       input logic [15:0] wd, input int npre,
                       output logic [15:0] rd);
    logic [31:0] body;
    int          j;
    body = {2'b00, op, prtad, dev, 2'b10, wd};
    rd   = 16'h0000;
    for (int k = 0; k < npre + 32; k++) begin
      j = k - npre;
      @(negedge core_clk);
      host_oe = !(op[1] && j >= 14);
      host_o  = (j < 0) ? 1'b1 : body[31-j];
      repeat (HALF) @(negedge core_clk);
      mdc = 1'b1;
      if (op[1] && j >= 16)
        rd = {rd[14:0], mdio_wire};
      repeat (HALF) @(negedge core_clk);
      mdc = 1'b0;
    end
    host_oe = 1'b0;
  endtask
endmodule

// ==== brpcs_status_regs_test.sv ====
// Self-checking bench for the base-R PCS status register bank.
// Assumes the package, the design and the host model are compiled first.
`timescale 1ns/1ps
module brpcs_status_regs_test;
  import brpcs_pkg::*;

  typedef struct packed {
    logic [4:0]  lv;    // tx, rx, link, hi_ber, lock levels
    logic [15:0] addr;
    logic [15:0] exp;
  } brpcs_row_s;

  logic            core_clk;
  logic            reset_n;
  logic            mdc;
  logic            mdio_o;
  logic            mdio_oe;
  logic            host_o;
  logic            host_oe;
  logic            kr_mode;
  brpcs_pcs_stat_s pcs_stat;
  logic [31:0]     test_seed_a;
  logic [15:0]     rdat;
  int              n_errors;
  int              checks;
  brpcs_row_s      rows [18];
  wire logic       mdio_line;

  // Shared wire, pulled high when nobody drives
  assign mdio_line = mdio_oe ? mdio_o : (host_oe ? host_o : 1'b1);

  // 40 MHz core clock
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  brpcs_status_regs #(.PORT_ADDR(5'h05)) i_brpcs_status_regs (
    .core_clk(core_clk), .reset_n(reset_n), .mdc(mdc),
    .mdio_i(mdio_line), .mdio_o(mdio_o), .mdio_oe(mdio_oe),
    .kr_mode(kr_mode), .pcs_stat(pcs_stat), .test_seed_a(test_seed_a));

  brpcs_mdio_host i_brpcs_mdio_host (
    .core_clk(core_clk), .mdio_wire(mdio_line), .mdc(mdc),
    .host_o(host_o), .host_oe(host_oe));

  // Compare a 16-bit read
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: read %h, wanted %h", $time, got, exp);
    end
  endtask

  // Compare the seed output
  task automatic chk_seed(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seed %h, wanted %h", $time, got, exp);
    end
  endtask

  // One frame with a full preamble
  task automatic xfer(input logic [1:0] op, input logic [4:0] dev,
                      input logic [15:0] wd);
    i_brpcs_mdio_host.frame(op, dev, wd, 32, rdat);
  endtask

  // Address frame, then read frame and compare
  task automatic rd(input logic [4:0] dev, input logic [15:0] addr,
                    input logic [15:0] exp);
    xfer(OP_ADDR, dev, addr);
    xfer(OP_READ, dev, 16'h0000);
    chk(rdat, exp);
  endtask

  // One-cycle event pulses, each apart from the next
  task automatic pulse(input int nb, input int ne);
    repeat (nb) begin
      @(negedge core_clk) pcs_stat.bad_sh_entry = 1'b1;
      @(negedge core_clk) pcs_stat.bad_sh_entry = 1'b0;
    end
    repeat (ne) begin
      @(negedge core_clk) pcs_stat.rx_e_entry = 1'b1;
      @(negedge core_clk) pcs_stat.rx_e_entry = 1'b0;
    end
  endtask

  // Counts, verdict and end of run
  task automatic summarize;
    $display("checks %0d, mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Hang guard
  initial begin
    repeat (100000) @(posedge core_clk);
    n_errors++;
    $display("unexpected at %0t: run did not finish", $time);
    summarize();
  end

  // Main sequence
  initial begin
    reset_n  = 1'b0;
    kr_mode  = 1'b1;
    pcs_stat = brpcs_pcs_stat_s'(7'h14);
    n_errors = 0;
    checks   = 0;
    rows = '{
      '{5'h05, 16'h0020, 16'h1005},
      '{5'h05, 16'h0001, 16'h0002},
      '{5'h05, 16'h0001, 16'h0006},
      '{5'h05, 16'h0008, 16'h8001},
      '{5'h05, 16'h0021, 16'h0000},
      '{5'h05, 16'h0021, 16'h8000},
      '{5'h15, 16'h0001, 16'h0086},
      '{5'h15, 16'h0008, 16'h8801},
      '{5'h05, 16'h0001, 16'h0086},
      '{5'h05, 16'h0008, 16'h8801},
      '{5'h05, 16'h0001, 16'h0006},
      '{5'h0D, 16'h0008, 16'h8401},
      '{5'h05, 16'h0008, 16'h8401},
      '{5'h05, 16'h0008, 16'h8001},
      '{5'h02, 16'h0020, 16'h0006},
      '{5'h05, 16'h0001, 16'h0002},
      '{5'h05, 16'h0021, 16'h4000},
      '{5'h05, 16'h0021, 16'h8000}
    };
    repeat (8) @(negedge core_clk);
    chk_seed(test_seed_a, 32'h0000_0000);
    chk({15'h0000, mdio_oe}, 16'h0000);
    reset_n = 1'b1;
    repeat (4) @(negedge core_clk);
    $display("test reset done");

    // Table of plain reads, levels applied before each access
    foreach (rows[i]) begin
      pcs_stat = brpcs_pcs_stat_s'({rows[i].lv, 2'b00});
      rd(DEVAD_PCS, rows[i].addr, rows[i].exp);
    end
    $display("test table done");

    // Counters, clear on read, shared errored-block alias
    pulse(3, 5);
    rd(DEVAD_PCS, LAT_CNT_OFS, 16'h8305);
    rd(DEVAD_PCS, LAT_CNT_OFS, 16'h8000);
    pulse(1, 2);
    rd(DEVAD_VEND, VEND_ERRBLK_OFS, 16'h0002);
    rd(DEVAD_PCS, LAT_CNT_OFS, 16'h8100);
    // Bad-header count stops at its maximum
    pulse(70, 0);
    rd(DEVAD_PCS, LAT_CNT_OFS, 16'hBF00);
    $display("test counters done");

    // Seed words, then read and read-increment
    xfer(OP_ADDR, DEVAD_PCS, SEED_A0_OFS);
    xfer(OP_WRITE, DEVAD_PCS, 16'hA5C3);
    xfer(OP_ADDR, DEVAD_PCS, SEED_A1_OFS);
    xfer(OP_WRITE, DEVAD_PCS, 16'h1E70);
    chk_seed(test_seed_a, 32'h1E70_A5C3);
    xfer(OP_ADDR, DEVAD_PCS, SEED_A0_OFS);
    xfer(OP_RDINC, DEVAD_PCS, 16'h0000);
    chk(rdat, 16'hA5C3);
    xfer(OP_READ, DEVAD_PCS, 16'h0000);
    chk(rdat, 16'h1E70);
    $display("test seeds done");

    // Refused frames leave the line to the pull-up
    i_brpcs_mdio_host.frame(OP_READ, DEVAD_PCS, 16'h0000, 16, rdat);
    chk(rdat, 16'hFFFF);
    kr_mode = 1'b0;
    xfer(OP_READ, DEVAD_PCS, 16'h0000);
    chk(rdat, 16'hFFFF);
    kr_mode = 1'b1;
    xfer(OP_READ, 5'h05, 16'h0000);
    chk(rdat, 16'hFFFF);
    i_brpcs_mdio_host.prtad = 5'h06;
    xfer(OP_READ, DEVAD_PCS, 16'h0000);
    chk(rdat, 16'hFFFF);
    i_brpcs_mdio_host.prtad = 5'h05;
    xfer(OP_READ, DEVAD_PCS, 16'h0000);
    chk(rdat, 16'h1E70);
    $display("test refusals done");

    // Mid-run reset clears the seeds, the data line stays released
    @(negedge core_clk) reset_n = 1'b0;
    repeat (2) @(negedge core_clk);
    chk_seed(test_seed_a, 32'h0000_0000);
    chk({15'h0000, mdio_oe}, 16'h0000);
    reset_n = 1'b1;
    repeat (4) @(negedge core_clk);
    rd(DEVAD_PCS, SEED_A1_OFS, 16'h0000);
    $display("test second reset done");
    summarize();
  end
endmodule
